// ===== cmr_defs.svh
// offsets, field positions, reset values and widths of the cache maintenance range registers
`ifndef CMR_DEFS_SVH
`define CMR_DEFS_SVH

`define CMR_ADDR_W          6
`define CMR_DATA_W          32
`define CMR_CNT_W           16
`define CMR_N_OPS           4
`define CMR_WORD_BYTES      4

`define CMR_OFS_L2C_START   6'h00
`define CMR_OFS_L2C_COUNT   6'h04
`define CMR_OFS_L2F_START   6'h08
`define CMR_OFS_L2F_COUNT   6'h0c
`define CMR_OFS_PI_START    6'h10
`define CMR_OFS_PI_COUNT    6'h14
`define CMR_OFS_DF_START    6'h18
`define CMR_OFS_DF_COUNT    6'h1c
`define CMR_OFS_STATUS      6'h20
`define CMR_OFS_CTRL        6'h24
`define CMR_OFS_EVENT       6'h28

`define CMR_START_RST       32'h0000_0000
`define CMR_CNT_RST         16'h0000
`define CMR_CTRL_EN_RST     1'b1
`define CMR_EVT_RST         9'h000

`define CMR_CTRL_EN_BIT     0
`define CMR_CTRL_ABORT_BIT  1
`define CMR_STAT_PEND_LSB   0
`define CMR_STAT_ACT_LSB    4
`define CMR_STAT_BUSY_BIT   8
`define CMR_STAT_REM_LSB    16
`define CMR_EVT_DONE_LSB    0
`define CMR_EVT_ERR_LSB     4
`define CMR_EVT_ABORT_BIT   8
`define CMR_EVT_W           9

`endif

// ===== cmr_grant_pick.sv
// lowest-index-first pick among pending maintenance requests
`timescale 1ns/1ps
module cmr_grant_pick #(
  parameter int N  = 4,
  parameter int IW = (N > 1) ? $clog2(N) : 1
) (
  input  wire logic [N-1:0]  req,
  output logic               any,
  output logic [IW-1:0]      idx,
  output logic [N-1:0]       onehot
);

  always_comb
  begin
    any    = 1'b0;
    idx    = '0;
    onehot = '0;
    // scan downward so the lowest index is the last to overwrite
    for (int i = N - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        any    = 1'b1;
        idx    = IW'(i);
        onehot = '0;
        onehot[i] = 1'b1;
      end
    end
  end

endmodule

// ===== cmr_monitor.sv
// assertion checker for the cache maintenance range register bank
`timescale 1ns/1ps
`include "cmr_defs.svh"
module cmr_monitor (
  input wire logic        CLOCK,
  input wire logic        RESET,
  input wire logic [5:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0]  AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  input wire logic        MAINT_VALID,
  input wire logic        MAINT_READY,
  input wire logic [31:0] MAINT_ADDR,
  input cmr_pkg::cmr_op_t MAINT_OP,
  input wire logic        MAINT_DONE,
  input wire logic        MAINT_BUSY
);
  import cmr_pkg::*;
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RESET);
  logic en_reg;
  wire  cnt_sel = !AVS_ADDRESS[5] && AVS_ADDRESS[2];
  // mirror of the enable bit, so a held-off launch is not mistaken for a missing one
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
      en_reg <= 1'b1;
    else if (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == `CMR_OFS_CTRL && AVS_BYTEENABLE[0])
      en_reg <= AVS_WRITEDATA[0];
  end
  sequence s_cnt_go;
    AVS_WRITE && !AVS_WAITREQUEST && cnt_sel && AVS_WRITEDATA[15:0] != 16'h0000
      && AVS_BYTEENABLE == 4'hf && !MAINT_BUSY && en_reg;
  endsequence
  sequence s_launch;
    ##[1:2] MAINT_BUSY ##[1:3] MAINT_VALID;
  endsequence
  property p_go;
    s_cnt_go |-> s_launch;
  endproperty
  a_go: assert property (p_go) else $error("count write did not launch");
  property p_cnt_hi;
    AVS_READ && !AVS_WAITREQUEST && cnt_sel |-> AVS_READDATA[31:16] == 16'h0000;
  endproperty
  a_cnt_hi: assert property (p_cnt_hi) else $error("count upper half not zero");
  property p_wr_pulse;
    !AVS_WAITREQUEST |=> AVS_WAITREQUEST;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("waitrequest low twice");
  property p_wr_cause;
    !AVS_READ && !AVS_WRITE |=> AVS_WAITREQUEST;
  endproperty
  a_wr_cause: assert property (p_wr_cause) else $error("answer without request");
  property p_hold;
    MAINT_VALID && !MAINT_READY |=> MAINT_VALID && $stable(MAINT_ADDR);
  endproperty
  a_hold: assert property (p_hold) else $error("word request dropped");
  property p_step;
    MAINT_VALID && MAINT_READY ##1 MAINT_VALID |-> MAINT_ADDR == $past(MAINT_ADDR) + 32'h4;
  endproperty
  a_step: assert property (p_step) else $error("word address step wrong");
  property p_done;
    MAINT_DONE |-> MAINT_BUSY ##1 !MAINT_DONE;
  endproperty
  a_done: assert property (p_done) else $error("done pulse malformed");
  property p_vbusy;
    MAINT_VALID |-> MAINT_BUSY && !MAINT_DONE;
  endproperty
  a_vbusy: assert property (p_vbusy) else $error("word request while idle");
  property p_op;
    MAINT_VALID |-> $stable(MAINT_OP);
  endproperty
  a_op: assert property (p_op) else $error("operation changed mid range");
endmodule

// ===== cmr_pkg.sv
// types shared by the cache maintenance range register bank
package cmr_pkg;

  typedef enum logic [1:0] {
    CMR_OP_L2_CLEAN,
    CMR_OP_L2_FLUSH,
    CMR_OP_PROG_INVAL,
    CMR_OP_DATA_FLUSH
  } cmr_op_t;

  typedef enum {
    CMR_SEQ_IDLE,
    CMR_SEQ_LAUNCH,
    CMR_SEQ_WALK
  } cmr_seq_t;

  typedef enum {
    CMR_WALK_IDLE,
    CMR_WALK_REQ
  } cmr_walk_t;

endpackage

// ===== cmr_range_walker.sv
// steps through an address range one word per accepted request
`timescale 1ns/1ps
`include "cmr_defs.svh"
module cmr_range_walker #(
  parameter int ADDR_W = `CMR_DATA_W,
  parameter int CNT_W  = `CMR_CNT_W,
  parameter int STEP   = `CMR_WORD_BYTES
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              start,
  input  wire logic [ADDR_W-1:0] base,
  input  wire logic [CNT_W-1:0]  count,
  input  wire logic              abort,
  input  wire logic              req_ready,
  output logic                   req_valid,
  output logic [ADDR_W-1:0]      req_addr,
  output logic [CNT_W-1:0]       remain,
  output logic                   done,
  output logic                   aborted
);
  import cmr_pkg::*;

  cmr_walk_t state_reg;
  logic      last_word;

  assign last_word = (remain == CNT_W'(1));

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= CMR_WALK_IDLE;
      req_valid <= 1'b0;
      req_addr  <= '0;
      remain    <= '0;
      done      <= 1'b0;
      aborted   <= 1'b0;
    end
    else
    begin
      done    <= 1'b0;
      aborted <= 1'b0;
      case (state_reg)
        CMR_WALK_IDLE:
        begin
          if (start && (count != '0))
          begin
            state_reg <= CMR_WALK_REQ;
            req_valid <= 1'b1;
            req_addr  <= base;
            remain    <= count;
          end
        end
        CMR_WALK_REQ:
        begin
          // abort only at a word boundary so valid never drops unaccepted
          if (req_ready)
          begin
            if (last_word || abort)
            begin
              state_reg <= CMR_WALK_IDLE;
              req_valid <= 1'b0;
              remain    <= '0;
              done      <= 1'b1;
              aborted   <= abort && !last_word;
            end
            else
            begin
              req_addr <= req_addr + ADDR_W'(STEP);
              remain   <= remain - CNT_W'(1);
            end
          end
        end
        default:
        begin
          state_reg <= CMR_WALK_IDLE;
          req_valid <= 1'b0;
        end
      endcase
    end
  end

endmodule

// ===== cmr_regs.sv
// register bank and launcher for range-based cache maintenance operations
`timescale 1ns/1ps
`include "cmr_defs.svh"
module cmr_regs (
  input  wire logic                   CLOCK,
  input  wire logic                   RESET,
  input  wire logic [5:0]             AVS_ADDRESS,
  input  wire logic                   AVS_READ,
  input  wire logic                   AVS_WRITE,
  input  wire logic [31:0]            AVS_WRITEDATA,
  input  wire logic [3:0]             AVS_BYTEENABLE,
  output logic      [31:0]            AVS_READDATA,
  output logic                        AVS_WAITREQUEST,
  output logic                        MAINT_VALID,
  input  wire logic                   MAINT_READY,
  output logic      [31:0]            MAINT_ADDR,
  output cmr_pkg::cmr_op_t            MAINT_OP,
  output logic                        MAINT_DONE,
  output logic                        MAINT_BUSY
);
  import cmr_pkg::*;

  localparam int N  = `CMR_N_OPS;
  localparam int CW = `CMR_CNT_W;
  localparam int DW = `CMR_DATA_W;

  localparam logic [5:0] START_OFS [N] = '{`CMR_OFS_L2C_START, `CMR_OFS_L2F_START,
                                           `CMR_OFS_PI_START, `CMR_OFS_DF_START};
  localparam logic [5:0] COUNT_OFS [N] = '{`CMR_OFS_L2C_COUNT, `CMR_OFS_L2F_COUNT,
                                           `CMR_OFS_PI_COUNT, `CMR_OFS_DF_COUNT};

  // registers
  logic [DW-1:0]          start_reg [N];
  logic [CW-1:0]          count_reg [N];
  logic [N-1:0]           pend_reg;
  logic                   en_reg;
  logic                   abort_reg;
  logic [`CMR_EVT_W-1:0]  evt_reg;
  logic [`CMR_EVT_W-1:0]  evt_next;
  logic                   wait_reg;
  logic [DW-1:0]          rdata_reg;
  cmr_seq_t               seq_reg;
  cmr_op_t                op_reg;
  logic                   busy_reg;
  logic                   launch_reg;
  logic [DW-1:0]          snap_base_reg;
  logic [CW-1:0]          snap_cnt_reg;

  // bus decode
  logic [5:0]             word_ofs;
  logic                   wr_fire;
  logic                   blocked;
  logic [DW-1:0]          rd_mux;
  logic [N-1:0]           hit_start;
  logic [N-1:0]           hit_count;
  logic [DW-1:0]          merged_start [N];
  logic [DW-1:0]          merged_count [N];
  logic [N-1:0]           set_pend;
  logic [N-1:0]           set_err;
  logic [N-1:0]           act_vec;

  // arbitration and walker
  logic                   pick_any;
  logic [1:0]             pick_idx;
  logic [N-1:0]           pick_onehot;
  logic [N-1:0]           grant_vec;
  logic                   walk_valid;
  logic [DW-1:0]          walk_addr;
  logic [CW-1:0]          walk_remain;
  logic                   walk_done;
  logic                   walk_aborted;

  function automatic logic [DW-1:0] be_merge(input logic [DW-1:0] old_v,
                                             input logic [DW-1:0] new_v,
                                             input logic [3:0]    be);
    logic [DW-1:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // byte address; the two low bits are ignored, registers are aligned words
  assign word_ofs = {AVS_ADDRESS[5:2], 2'b00};
  assign wr_fire  = AVS_WRITE && !wait_reg;

  genvar ch;
  generate
    for (ch = 0; ch < N; ch++)
    begin : g_chan
      assign hit_start[ch]    = (word_ofs == START_OFS[ch]);
      assign hit_count[ch]    = (word_ofs == COUNT_OFS[ch]);
      assign merged_start[ch] = be_merge(start_reg[ch], AVS_WRITEDATA, AVS_BYTEENABLE);
      assign merged_count[ch] = be_merge({16'h0000, count_reg[ch]}, AVS_WRITEDATA, AVS_BYTEENABLE);
      assign act_vec[ch]      = busy_reg && (op_reg == cmr_op_t'(ch));
      assign set_pend[ch]     = wr_fire && hit_count[ch] && (merged_count[ch][CW-1:0] != '0);
      // nonzero upper count bits are flagged, never stored
      assign set_err[ch]      = wr_fire && hit_count[ch] && (merged_count[ch][DW-1:CW] != '0);

      always_ff @(posedge CLOCK)
      begin
        if (RESET)
        begin
          start_reg[ch] <= `CMR_START_RST;
        end
        else if (wr_fire && hit_start[ch])
        begin
          start_reg[ch] <= merged_start[ch];
        end
      end

      always_ff @(posedge CLOCK)
      begin
        if (RESET)
        begin
          count_reg[ch] <= `CMR_CNT_RST;
        end
        else if (wr_fire && hit_count[ch])
        begin
          count_reg[ch] <= merged_count[ch][CW-1:0];
        end
      end
    end
  endgenerate

  // a count write to a channel still queued or running is stalled, not dropped
  assign blocked = AVS_WRITE && ((hit_count & (pend_reg | act_vec)) != '0);

  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      wait_reg <= 1'b1;
    end
    else if ((AVS_READ || AVS_WRITE) && wait_reg && !blocked)
    begin
      wait_reg <= 1'b0;
    end
    else
    begin
      wait_reg <= 1'b1;
    end
  end

  always_comb
  begin
    rd_mux = '0;
    for (int i = 0; i < N; i++)
    begin
      if (hit_start[i])
      begin
        rd_mux = start_reg[i];
      end
      if (hit_count[i])
      begin
        rd_mux = {16'h0000, count_reg[i]};
      end
    end
    if (word_ofs == `CMR_OFS_STATUS)
    begin
      rd_mux = '0;
      rd_mux[`CMR_STAT_PEND_LSB +: N]  = pend_reg;
      rd_mux[`CMR_STAT_ACT_LSB +: N]   = act_vec;
      rd_mux[`CMR_STAT_BUSY_BIT]       = busy_reg;
      rd_mux[`CMR_STAT_REM_LSB +: CW]  = walk_remain;
    end
    if (word_ofs == `CMR_OFS_CTRL)
    begin
      rd_mux = '0;
      rd_mux[`CMR_CTRL_EN_BIT]    = en_reg;
      rd_mux[`CMR_CTRL_ABORT_BIT] = abort_reg;
    end
    if (word_ofs == `CMR_OFS_EVENT)
    begin
      rd_mux = '0;
      rd_mux[`CMR_EVT_W-1:0] = evt_reg;
    end
  end

  // reloaded during every wait cycle so the word is settled at the answering edge
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      rdata_reg <= '0;
    end
    else if (AVS_READ && wait_reg)
    begin
      rdata_reg <= rd_mux;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      en_reg <= `CMR_CTRL_EN_RST;
    end
    else if (wr_fire && (word_ofs == `CMR_OFS_CTRL) && AVS_BYTEENABLE[0])
    begin
      en_reg <= AVS_WRITEDATA[`CMR_CTRL_EN_BIT];
    end
  end

  // abort is only accepted while an operation runs and ends with it
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      abort_reg <= 1'b0;
    end
    else if (!busy_reg || walk_done)
    begin
      abort_reg <= 1'b0;
    end
    else if (wr_fire && (word_ofs == `CMR_OFS_CTRL) && AVS_BYTEENABLE[0]
             && AVS_WRITEDATA[`CMR_CTRL_ABORT_BIT])
    begin
      abort_reg <= 1'b1;
    end
  end

  // pending: a new set wins over the grant that clears it
  assign grant_vec = (seq_reg == CMR_SEQ_IDLE && en_reg && pick_any) ? pick_onehot : '0;

  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      pend_reg <= '0;
    end
    else
    begin
      pend_reg <= (pend_reg & ~grant_vec) | set_pend;
    end
  end

  cmr_grant_pick #(
    .N      (N),
    .IW     (2)
  ) u_pick (
    .req    (pend_reg),
    .any    (pick_any),
    .idx    (pick_idx),
    .onehot (pick_onehot)
  );

  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      seq_reg       <= CMR_SEQ_IDLE;
      op_reg        <= CMR_OP_L2_CLEAN;
      busy_reg      <= 1'b0;
      launch_reg    <= 1'b0;
      snap_base_reg <= '0;
      snap_cnt_reg  <= '0;
    end
    else
    begin
      launch_reg <= 1'b0;
      case (seq_reg)
        CMR_SEQ_IDLE:
        begin
          if (en_reg && pick_any)
          begin
            // base and count are captured here, later start writes do not disturb the walk
            seq_reg       <= CMR_SEQ_LAUNCH;
            op_reg        <= cmr_op_t'(pick_idx);
            busy_reg      <= 1'b1;
            launch_reg    <= 1'b1;
            snap_base_reg <= start_reg[pick_idx];
            snap_cnt_reg  <= count_reg[pick_idx];
          end
        end
        CMR_SEQ_LAUNCH:
        begin
          seq_reg <= CMR_SEQ_WALK;
        end
        CMR_SEQ_WALK:
        begin
          if (walk_done)
          begin
            seq_reg  <= CMR_SEQ_IDLE;
            busy_reg <= 1'b0;
          end
        end
        default:
        begin
          seq_reg  <= CMR_SEQ_IDLE;
          busy_reg <= 1'b0;
        end
      endcase
    end
  end

  cmr_range_walker #(
    .ADDR_W    (DW),
    .CNT_W     (CW),
    .STEP      (`CMR_WORD_BYTES)
  ) u_walk (
    .clk       (CLOCK),
    .rst       (RESET),
    .start     (launch_reg),
    .base      (snap_base_reg),
    .count     (snap_cnt_reg),
    .abort     (abort_reg),
    .req_ready (MAINT_READY),
    .req_valid (walk_valid),
    .req_addr  (walk_addr),
    .remain    (walk_remain),
    .done      (walk_done),
    .aborted   (walk_aborted)
  );

  // event flags: write one to clear, a same-cycle set wins
  always_comb
  begin
    evt_next = evt_reg;
    if (wr_fire && (word_ofs == `CMR_OFS_EVENT))
    begin
      evt_next = evt_reg & ~`CMR_EVT_W'(be_merge('0, AVS_WRITEDATA, AVS_BYTEENABLE));
    end
    evt_next[`CMR_EVT_ERR_LSB +: N] = evt_next[`CMR_EVT_ERR_LSB +: N] | set_err;
    if (walk_done)
    begin
      evt_next[`CMR_EVT_DONE_LSB + 32'(op_reg)] = 1'b1;
    end
    if (walk_aborted)
    begin
      evt_next[`CMR_EVT_ABORT_BIT] = 1'b1;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      evt_reg <= `CMR_EVT_RST;
    end
    else
    begin
      evt_reg <= evt_next;
    end
  end

  assign AVS_READDATA    = rdata_reg;
  assign AVS_WAITREQUEST = wait_reg;
  assign MAINT_VALID     = walk_valid;
  assign MAINT_ADDR      = walk_addr;
  assign MAINT_OP        = op_reg;
  assign MAINT_DONE      = walk_done;
  assign MAINT_BUSY      = busy_reg;

endmodule

// ===== tb.sv
// self-checking bench for the cache maintenance range register bank
`timescale 1ns/1ps
`include "cmr_defs.svh"
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("MISMATCH %0t got %h exp %h", $time, got, exp); end end
module tb;
  import cmr_pkg::*;
  logic        CLOCK, RESET, AVS_READ, AVS_WRITE, MAINT_READY;
  logic [5:0]  AVS_ADDRESS;
  logic [3:0]  AVS_BYTEENABLE;
  logic [31:0] AVS_WRITEDATA;
  wire  [31:0] AVS_READDATA, MAINT_ADDR;
  wire         AVS_WAITREQUEST, MAINT_VALID, MAINT_DONE, MAINT_BUSY;
  cmr_op_t     MAINT_OP;
  int          error_cnt = 0;
  int          total_checks = 0;
  int          cyc = 0;
  cmr_regs u_dut (.CLOCK(CLOCK), .RESET(RESET), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .MAINT_VALID(MAINT_VALID),
    .MAINT_READY(MAINT_READY), .MAINT_ADDR(MAINT_ADDR), .MAINT_OP(MAINT_OP), .MAINT_DONE(MAINT_DONE),
    .MAINT_BUSY(MAINT_BUSY));
  initial
  begin
    CLOCK = 1'b0;
    forever #20 CLOCK = ~CLOCK;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // one edge before raising, so a release and the next request never share a time step
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge CLOCK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    do @(posedge CLOCK); while (AVS_WAITREQUEST !== 1'b0);
    q = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK(q, e)
  endtask
  // engine side stalls two cycles before every word
  task automatic walk(input logic [31:0] b, input int n, input cmr_op_t op, input logic last);
    for (int k = 0; k < n; k++)
    begin
      MAINT_READY <= 1'b0;
      repeat (2) @(posedge CLOCK);
      MAINT_READY <= 1'b1;
      do @(posedge CLOCK); while (MAINT_VALID !== 1'b1);
      `CHK(MAINT_ADDR, b + 32'(4 * k))
      `CHK(MAINT_OP, op)
    end
    MAINT_READY <= 1'b0;
    do @(posedge CLOCK); while (MAINT_DONE !== 1'b1);
    repeat (2) @(posedge CLOCK);
    if (last)
      `CHK(MAINT_BUSY, 1'b0)
  endtask
  task automatic t_regs();
    for (int i = 0; i < 4; i++)
    begin
      rd(`CMR_OFS_L2C_START + 6'(8 * i), 32'h0);
      rd(`CMR_OFS_L2C_COUNT + 6'(8 * i), 32'h0);
      wr(`CMR_OFS_L2C_START + 6'(8 * i), 32'hffff_fff0 | 32'(i));
      rd(`CMR_OFS_L2C_START + 6'(8 * i), 32'hffff_fff0 | 32'(i));
      wr(`CMR_OFS_L2C_COUNT + 6'(8 * i), 32'hffff_0000);
      rd(`CMR_OFS_L2C_COUNT + 6'(8 * i), 32'h0);
      `CHK(MAINT_BUSY, 1'b0)
    end
    AVS_BYTEENABLE <= 4'h2;
    wr(`CMR_OFS_L2C_START, 32'h1234_5678);
    AVS_BYTEENABLE <= 4'hf;
    rd(`CMR_OFS_L2C_START, 32'hffff_56f0);
    wr(6'h3c, 32'hffff_ffff);
    rd(6'h3c, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_ops();
    logic [31:0] b;
    for (int i = 0; i < 4; i++)
    begin
      // last range crosses the top of the address space
      b = (i == 3) ? 32'hffff_fffc : 32'(32'h0001_0000 * (i + 1));
      wr(`CMR_OFS_L2C_START + 6'(8 * i), b);
      wr(`CMR_OFS_L2C_COUNT + 6'(8 * i), 32'h0000_0003);
      walk(b, 3, cmr_op_t'(i), 1'b1);
      rd(`CMR_OFS_L2C_COUNT + 6'(8 * i), 32'h0000_0003);
    end
    $display("test ops done");
  endtask
  task automatic t_order();
    wr(`CMR_OFS_CTRL, 32'h0);
    wr(`CMR_OFS_DF_START, 32'h0000_1000);
    wr(`CMR_OFS_L2F_START, 32'h0000_2000);
    wr(`CMR_OFS_DF_COUNT, 32'h1);
    wr(`CMR_OFS_L2F_COUNT, 32'h1);
    repeat (4) @(posedge CLOCK);
    `CHK(MAINT_BUSY, 1'b0)
    wr(`CMR_OFS_CTRL, 32'h1);
    walk(32'h0000_2000, 1, CMR_OP_L2_FLUSH, 1'b0);
    walk(32'h0000_1000, 1, CMR_OP_DATA_FLUSH, 1'b1);
    $display("test order done");
  endtask
  // abort taken mid range: one word goes out, then the operation ends early
  task automatic t_abort();
    wr(`CMR_OFS_PI_START, 32'h0000_3000);
    wr(`CMR_OFS_PI_COUNT, 32'h0000_0004);
    wr(`CMR_OFS_CTRL, 32'h0000_0003);
    rd(`CMR_OFS_CTRL, 32'h0000_0003);
    rd(`CMR_OFS_STATUS, 32'h0004_0140);
    walk(32'h0000_3000, 1, CMR_OP_PROG_INVAL, 1'b1);
    rd(`CMR_OFS_CTRL, 32'h0000_0001);
    rd(`CMR_OFS_EVENT, 32'h0000_01ff);
    wr(`CMR_OFS_EVENT, 32'h0000_01ff);
    rd(`CMR_OFS_EVENT, 32'h0000_0000);
    rd(`CMR_OFS_STATUS, 32'h0000_0000);
    $display("test abort done");
  endtask
  // a few hundred cycles are expected; the ceiling leaves wide margin
  initial
  begin
    forever
    begin
      @(posedge CLOCK);
      cyc++;
      if (cyc == 5000)
      begin
        error_cnt++;
        test_done();
      end
    end
  end
  initial
  begin
    RESET = 1'b1;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_ADDRESS = 6'h00;
    AVS_WRITEDATA = 32'h0;
    AVS_BYTEENABLE = 4'hf;
    MAINT_READY = 1'b0;
    repeat (4) @(posedge CLOCK);
    RESET <= 1'b0;
    t_regs();
    t_ops();
    t_order();
    t_abort();
    test_done();
  end
endmodule
bind cmr_regs cmr_monitor u_mon (.CLOCK(CLOCK), .RESET(RESET), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
  .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .MAINT_VALID(MAINT_VALID), .MAINT_READY(MAINT_READY), .MAINT_ADDR(MAINT_ADDR), .MAINT_OP(MAINT_OP),
  .MAINT_DONE(MAINT_DONE), .MAINT_BUSY(MAINT_BUSY));
